// ---- bench/pps_port_bench.sv ----
// self-checking bench for the parallel port register block
`timescale 1ns/1ps
`default_nettype none
module pps_port_bench;
	import pps_pkg::*;
	logic       core_clk = 0, rst = 1, io_rd = 0, io_wr = 0, io_rready = 1;
	logic       bidir_mode = 0, fault_n_in = 1, printer_online_in = 0;
	logic       paper_out_in = 0, io_rvalid, io_wready, irq7, ack_n, busy;
	logic [9:0] io_addr = 0;
	logic [7:0] io_wdata = 0, io_rdata, pat = 0, d_o, d_oe, d_w, d, c, e;
	logic [7:0] q[$];
	logic [3:0] ext = 0, oe, cw;
	int         fails = 0, compares = 0, irqs = 0, want = 0, cyc = 0;
	pps_port dut (.core_clk, .rst, .clk_en(1'b1), .io_addr, .io_rd, .io_wr,
		.io_wdata, .io_rdata, .io_rvalid, .io_rready, .io_wready, .bidir_mode,
		.port_data_bits_in(d_w), .port_data_bits_out(d_o),
		.port_data_bits_oe(d_oe), .fault_n_in, .printer_online_in,
		.paper_out_in, .ack_n_in(ack_n), .busy_in(busy), .strobe_n_in(cw[0]),
		.strobe_n_out(), .strobe_n_oe(oe[0]), .line_feed_automatic_in(cw[1]),
		.line_feed_automatic_out(), .line_feed_automatic_oe(oe[1]),
		.init_n_in(cw[2]), .init_n_out(), .init_n_oe(oe[2]),
		.printer_choose_in(cw[3]), .printer_choose_out(),
		.printer_choose_oe(oe[3]), .irq7);
	pps_printer far (.core_clk, .ctl_oe(oe), .ext_low(ext), .d_out(d_o),
		.d_oe, .pat, .ctl_wire(cw), .d_wire(d_w), .ack_n, .busy);
	initial forever #5 core_clk = ~core_clk;
	task automatic results;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wt(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// request held until an edge sees ready, then released
	task automatic acc(logic [9:0] a, logic r, logic [7:0] v);
		io_addr = a;
		io_rd = r;
		io_wr = !r;
		io_wdata = v;
		while (io_wready !== 1'b1)
			wt(1);
		wt(1);
		io_rd = 0;
		io_wr = 0;
	endtask
	task automatic rd(logic [9:0] a, logic [7:0] x);
		q.push_back(x);
		acc(a, 1, 8'h00);
	endtask
	// sampled mid-cycle so the pop edge is never raced
	always @(negedge core_clk) begin
		cyc++;
		if (irq7 === 1'b1)
			irqs++;
		if (io_rvalid === 1'b1 && io_rready === 1'b1)
			chk(io_rdata, q.pop_front());
		if (cyc == 5000) begin
			fails++;
			results();
		end
	end
	initial begin
		void'($urandom(32'h2954));
		wt(2);
		rst = 0;
		rd(PPS_CONTROL_ADDR, 8'hc4);
		rd(10'h37b, PPS_UNMAPPED_READ);
		for (int i = 0; i < 16; i++) begin
			{bidir_mode, fault_n_in, printer_online_in, paper_out_in} = 4'($urandom);
			ext = 4'($urandom) & 4'he;
			pat = 8'($urandom);
			d = 8'($urandom);
			c = {2'b00, 6'($urandom)};
			acc(PPS_DATA_ADDR, 0, d);
			acc(PPS_CONTROL_ADDR, 0, c);
			wt(6);
			e = {!busy, ack_n, paper_out_in, printer_online_in, fault_n_in, 3'h0};
			rd(PPS_STATUS_ADDR, e);
			e = {2'h3, c[5:4], c[3] | ext[3], c[2] & !ext[2], c[1] | ext[1], c[0]};
			rd(PPS_CONTROL_ADDR, e);
			rd(PPS_DATA_ADDR, bidir_mode && c[5] ? pat : d);
			want += int'(c[0] & c[4]);
			wt(25);
			acc(PPS_CONTROL_ADDR, 0, c & 8'hfe);
		end
		// stalled reader: two unread words must refuse a third
		io_rready = 0;
		rd(10'h3ff, PPS_UNMAPPED_READ);
		rd(10'h37b, PPS_UNMAPPED_READ);
		wt(1);
		chk({7'h00, io_wready}, 8'h00);
		io_rready = 1;
		wt(4);
		chk(8'(irqs), 8'(want));
		results();
	end
endmodule
`default_nettype wire

// ---- bench/pps_port_chk.sv ----
// assertion checker for the parallel port register block
`timescale 1ns/1ps
`default_nettype none
module pps_port_chk
	import pps_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [9:0] io_addr,
	input wire logic       io_wr,
	input wire logic [7:0] io_wdata,
	input wire logic       io_wready,
	input wire logic       bidir_mode,
	input wire logic [7:0] port_data_bits_out,
	input wire logic [7:0] port_data_bits_oe,
	input wire logic       ack_n_in,
	input wire logic       strobe_n_oe,
	input wire logic       line_feed_automatic_oe,
	input wire logic       init_n_oe,
	input wire logic       printer_choose_oe,
	input wire logic       irq7
);
	// clk_en is held high by the bench, so it is left out here
	wire cw = io_wr && io_wready && io_addr == PPS_CONTROL_ADDR;
	wire dw = io_wr && io_wready && io_addr == PPS_DATA_ADDR;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	AST_DATA: assert property (dw |=> port_data_bits_out == $past(io_wdata))
		else $error("data lines differ from write");
	AST_STB: assert property (cw |=> strobe_n_oe == $past(io_wdata[0]))
		else $error("strobe drive wrong");
	AST_FEED: assert property (cw |=> line_feed_automatic_oe == $past(io_wdata[1]))
		else $error("line feed drive wrong");
	AST_INIT: assert property (cw |=> init_n_oe != $past(io_wdata[2]))
		else $error("init drive wrong");
	AST_CHS: assert property (cw |=> printer_choose_oe == $past(io_wdata[3]))
		else $error("choose drive wrong");
	// ack must have risen a few cycles before, after a low spell
	AST_IRQ: assert property (irq7 |-> $past(ack_n_in, 2) && !$past(ack_n_in, 7))
		else $error("interrupt without ack rise");
	AST_DIR: assert property (cw |=> port_data_bits_oe == {8{!(bidir_mode && $past(io_wdata[5]))}})
		else $error("direction bit ignored");
	AST_OUT: assert property (!bidir_mode && $stable(bidir_mode) |-> &port_data_bits_oe)
		else $error("data released in printer mode");
endmodule
bind pps_port pps_port_chk u_chk (.core_clk, .rst, .io_addr, .io_wr,
	.io_wdata, .io_wready, .bidir_mode, .port_data_bits_out,
	.port_data_bits_oe, .ack_n_in, .strobe_n_oe, .line_feed_automatic_oe,
	.init_n_oe, .printer_choose_oe, .irq7);
`default_nettype wire

// ---- bench/pps_printer.sv ----
// printer model on the far side of the parallel port
`timescale 1ns/1ps
`default_nettype none
module pps_printer (
	input  wire logic [3:0] ctl_oe,
	input  wire logic [3:0] ext_low,
	input  wire logic [7:0] d_out,
	input  wire logic [7:0] d_oe,
	input  wire logic [7:0] pat,
	input  wire logic       core_clk,
	output logic      [3:0] ctl_wire,
	output logic      [7:0] d_wire,
	output logic            ack_n,
	output logic            busy
);
	int   cnt = 0;
	logic stb_q = 1;
	// pull-ups win unless either side sinks the line
	assign ctl_wire = ~(ctl_oe | ext_low);
	// released bits show the pattern, never a stale value
	assign d_wire = (d_out & d_oe) | (pat & ~d_oe);
	assign busy = cnt != 0;
	assign ack_n = !(cnt inside {[1:6]});
	always @(posedge core_clk) begin
		stb_q <= ctl_wire[0];
		if (cnt != 0)
			cnt <= cnt - 1;
		else if (stb_q && !ctl_wire[0])
			cnt <= 20;
	end
endmodule
`default_nettype wire

// ---- hdl/pps_pkg.sv ----
// constants for the parallel port register block
package pps_pkg;
	localparam logic [9:0] PPS_DATA_ADDR      = 10'h378;
	localparam logic [9:0] PPS_STATUS_ADDR    = 10'h379;
	localparam logic [9:0] PPS_CONTROL_ADDR   = 10'h37a;
	localparam int         PPS_ST_FAULT       = 3;
	localparam int         PPS_ST_ONLINE      = 4;
	localparam int         PPS_ST_PAPER       = 5;
	localparam int         PPS_ST_ACK         = 6;
	localparam int         PPS_ST_BUSY        = 7;
	localparam int         PPS_CT_STROBE      = 0;
	localparam int         PPS_CT_FEED        = 1;
	localparam int         PPS_CT_INIT        = 2;
	localparam int         PPS_CT_CHOOSE      = 3;
	localparam int         PPS_CT_IRQ_GATE    = 4;
	localparam int         PPS_CT_DIR         = 5;
	localparam logic [7:0] PPS_DATA_RESET     = 8'h00;
	// init released high, strobe/feed/choose idle
	localparam logic [5:0] PPS_CONTROL_RESET  = 6'h04;
	localparam logic [1:0] PPS_CONTROL_ONES   = 2'h3;
	localparam logic [2:0] PPS_STATUS_ZEROS   = 3'h0;
	localparam logic [7:0] PPS_UNMAPPED_READ  = 8'hff;
	typedef enum logic [1:0] {
		PPS_BUF_EMPTY = 2'b00,
		PPS_BUF_ONE   = 2'b01,
		PPS_BUF_TWO   = 2'b10
	} pps_buf_state_t;
endpackage

// ---- hdl/pps_port.sv ----
// parallel port data, status and control register logic
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
module pps_port
	import pps_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	input  wire logic [9:0] io_addr,
	input  wire logic       io_rd,
	input  wire logic       io_wr,
	input  wire logic [7:0] io_wdata,
	output logic      [7:0] io_rdata,
	output logic            io_rvalid,
	input  wire logic       io_rready,
	output logic            io_wready,
	input  wire logic       bidir_mode,
	input  wire logic [7:0] port_data_bits_in,
	output logic      [7:0] port_data_bits_out,
	output logic      [7:0] port_data_bits_oe,
	input  wire logic       fault_n_in,
	input  wire logic       printer_online_in,
	input  wire logic       paper_out_in,
	input  wire logic       ack_n_in,
	input  wire logic       busy_in,
	input  wire logic       strobe_n_in,
	output logic            strobe_n_out,
	output logic            strobe_n_oe,
	input  wire logic       line_feed_automatic_in,
	output logic            line_feed_automatic_out,
	output logic            line_feed_automatic_oe,
	input  wire logic       init_n_in,
	output logic            init_n_out,
	output logic            init_n_oe,
	input  wire logic       printer_choose_in,
	output logic            printer_choose_out,
	output logic            printer_choose_oe,
	output logic            irq7
);

	// ==========================================================
	// pin synchronisers
	// every pin is foreign to core_clk, so two flops before any use
	logic [8:0] pin_raw;
	logic [8:0] pin_s1;
	logic [8:0] pin_s2;
	logic [7:0] data_s1;
	logic [7:0] data_s2;

	assign pin_raw[8] = fault_n_in;
	assign pin_raw[7] = printer_online_in;
	assign pin_raw[6] = paper_out_in;
	assign pin_raw[5] = ack_n_in;
	assign pin_raw[4] = busy_in;
	assign pin_raw[3] = strobe_n_in;
	assign pin_raw[2] = line_feed_automatic_in;
	assign pin_raw[1] = init_n_in;
	assign pin_raw[0] = printer_choose_in;

	// idle level is high, so pin flops reset to ones (data flops to zeros): no false edge after reset
	genvar gi;
	generate
		for (gi = 0; gi < 9; gi++) begin : g_pin_sync
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					pin_s1[gi] <= 1'b1;
					pin_s2[gi] <= 1'b1;
				end else if (clk_en) begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
				end
			end
		end
		for (gi = 0; gi < 8; gi++) begin : g_data_sync
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					data_s1[gi] <= 1'b0;
					data_s2[gi] <= 1'b0;
				end else if (clk_en) begin
					data_s1[gi] <= port_data_bits_in[gi];
					data_s2[gi] <= data_s1[gi];
				end
			end
		end
	endgenerate

	logic fault_n_s;
	logic online_s;
	logic paper_s;
	logic ack_n_s;
	logic busy_s;
	logic strobe_n_s;
	logic feed_n_s;
	logic init_n_s;
	logic choose_n_s;

	assign fault_n_s  = pin_s2[8];
	assign online_s   = pin_s2[7];
	assign paper_s    = pin_s2[6];
	assign ack_n_s    = pin_s2[5];
	assign busy_s     = pin_s2[4];
	assign strobe_n_s = pin_s2[3];
	assign feed_n_s   = pin_s2[2];
	assign init_n_s   = pin_s2[1];
	assign choose_n_s = pin_s2[0];

	// ==========================================================
	// register writes
	logic [7:0] port_data;
	logic [5:0] port_control;
	logic       wr_take;
	logic       wr_data;
	logic       wr_control;

	// writes share the read buffer's ready, so a full buffer stalls both
	assign wr_take    = io_wr && io_wready;
	assign wr_data    = wr_take && (io_addr == PPS_DATA_ADDR);
	assign wr_control = wr_take && (io_addr == PPS_CONTROL_ADDR);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			port_data <= PPS_DATA_RESET;
		end else if (clk_en) begin
			if (wr_data) begin
				port_data <= io_wdata;
			end
		end
	end

	// bits 7..6 are not stored, they read back as ones
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			port_control <= PPS_CONTROL_RESET;
		end else if (clk_en) begin
			if (wr_control) begin
				port_control <= io_wdata[5:0];
			end
		end
	end

	// ==========================================================
	// pin drive
	logic data_input;
	logic strobe_lvl;
	logic feed_lvl;
	logic init_lvl;
	logic choose_lvl;

	// printer mode ignores the direction bit
	assign data_input         = bidir_mode && port_control[PPS_CT_DIR];
	assign port_data_bits_out = port_data;
	assign port_data_bits_oe  = {8{~data_input}};

	// wire level each control bit asks for
	assign strobe_lvl = ~port_control[PPS_CT_STROBE];
	assign feed_lvl   = ~port_control[PPS_CT_FEED];
	assign init_lvl   = port_control[PPS_CT_INIT];
	assign choose_lvl = ~port_control[PPS_CT_CHOOSE];

	// open collector: out is tied low, the enable does the pulling,
	// so a released line can be read back as an input
	assign strobe_n_out            = 1'b0;
	assign strobe_n_oe             = ~strobe_lvl;

	assign line_feed_automatic_out = 1'b0;
	assign line_feed_automatic_oe  = ~feed_lvl;

	assign init_n_out              = 1'b0;
	assign init_n_oe               = ~init_lvl;

	assign printer_choose_out      = 1'b0;
	assign printer_choose_oe       = ~choose_lvl;

	// ==========================================================
	// acknowledge interrupt
	logic ack_prev;
	logic ack_rise;
	logic next_irq7;

	assign ack_rise  = ack_n_s && !ack_prev;
	assign next_irq7 = port_control[PPS_CT_IRQ_GATE] && ack_rise;

	// one-cycle pulse; the system line is edge triggered
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ack_prev <= 1'b1;
			irq7     <= 1'b0;
		end else if (clk_en) begin
			ack_prev <= ack_n_s;
			irq7     <= next_irq7;
		end
	end

	// ==========================================================
	// read decode
	logic [7:0] status_val;
	logic [7:0] control_val;
	logic [7:0] data_val;
	logic [7:0] rd_val;

	// pins arrive two cycles late through the synchronisers
	assign status_val[7]   = ~busy_s;
	assign status_val[6]   = ack_n_s;
	assign status_val[5]   = paper_s;
	assign status_val[4]   = online_s;
	assign status_val[3]   = fault_n_s;
	assign status_val[2:0] = PPS_STATUS_ZEROS;

	// bits 3..0 come from the wire: release a line before reading it
	assign control_val[7:6] = PPS_CONTROL_ONES;
	assign control_val[5]   = port_control[PPS_CT_DIR];
	assign control_val[4]   = port_control[PPS_CT_IRQ_GATE];
	assign control_val[3]   = ~choose_n_s;
	assign control_val[2]   = init_n_s;
	assign control_val[1]   = ~feed_n_s;
	assign control_val[0]   = ~strobe_n_s;

	assign data_val = data_input ? data_s2 : port_data;

	always_comb begin
		if (io_addr == PPS_DATA_ADDR) begin
			rd_val = data_val;
		end else if (io_addr == PPS_STATUS_ADDR) begin
			rd_val = status_val;
		end else if (io_addr == PPS_CONTROL_ADDR) begin
			rd_val = control_val;
		end else begin
			rd_val = PPS_UNMAPPED_READ;
		end
	end

	// ==========================================================
	// two-entry read buffer
	// two words of slack, so a stalled reader loses nothing
	pps_buf_state_t buf_state;
	pps_buf_state_t next_buf_state;
	logic [7:0]     buf_word [0:1];
	logic           rd_ptr;
	logic           wr_ptr;
	logic           buf_in_ready;
	logic           push;
	logic           pop;

	assign buf_in_ready = (buf_state != PPS_BUF_TWO);
	assign push         = io_rd && buf_in_ready;
	assign pop          = io_rvalid && io_rready;
	assign io_rvalid    = (buf_state != PPS_BUF_EMPTY);
	assign io_rdata     = buf_word[rd_ptr];
	assign io_wready    = buf_in_ready;

	// a push and a pop in one cycle leave the fill level alone
	always_comb begin
		next_buf_state = buf_state;
		case (buf_state)
			PPS_BUF_EMPTY: begin
				if (push) begin
					next_buf_state = PPS_BUF_ONE;
				end
			end
			PPS_BUF_ONE: begin
				if (push && !pop) begin
					next_buf_state = PPS_BUF_TWO;
				end else if (pop && !push) begin
					next_buf_state = PPS_BUF_EMPTY;
				end
			end
			PPS_BUF_TWO: begin
				if (pop) begin
					next_buf_state = PPS_BUF_ONE;
				end
			end
			default: begin
				next_buf_state = PPS_BUF_EMPTY;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			buf_state <= PPS_BUF_EMPTY;
		end else if (clk_en) begin
			buf_state <= next_buf_state;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
		end else if (clk_en) begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
		end
	end

	// the word is captured at the take edge, not when it is popped
	genvar ei;
	generate
		for (ei = 0; ei < 2; ei++) begin : g_buf_word
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					buf_word[ei] <= 8'h00;
				end else if (clk_en && push && (wr_ptr == 1'(ei))) begin
					buf_word[ei] <= rd_val;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire
